/* File: inc/cmp_event_pkg.sv */
// Constants for the five-unit compare/event block: map, fields, modes.
// Assumes a 32-bit AHB-Lite bus, one register per aligned word.
// How it works
// (R1) Compare value equals selected timer: match
// (R2) Match flag set with pin/trigger action
// (R3) Trigger clears timer, no overflow flag
// (R4) Fifth unit trigger starts conversion if enabled
// (R5) Software clears pin direction bit
// (R6) Pin select bits choose output pin
// (R7) Control written zero forces latch low
// (R8) Software runs timer synchronously
// (R9) Software avoids system-clock timer source
// (R10) Mode 1010: flag only, pin untouched
// (R11) Mode 1011: flag set on match
// (R12) Trigger clears timer on next tick
// (R13) Trigger mode never owns the pin
// (R14) Overflow flag only on real rollover
// (R15) Compare rewrite cancels pending timer clear
// (R16) Trigger mode makes compare a period
// (R17) No matches while clock stopped
// (R18) Other modes toggle, set, clear latch
// (R19) Timer select field picks one of three
package cmp_event_pkg;
  localparam int NUM_UNITS  = 5;
  localparam int NUM_TIMERS = 3;
  localparam int ADC_UNIT   = 4;

  // Byte addresses; blocks of words step by ADDR_STRIDE
  localparam logic [7:0] ADDR_CTRL_BASE = 8'h00;
  localparam logic [7:0] ADDR_CMP_BASE  = 8'h14;
  localparam logic [7:0] ADDR_TSEL_A    = 8'h28;
  localparam logic [7:0] ADDR_TSEL_B    = 8'h2C;
  localparam logic [7:0] ADDR_PIN_SEL   = 8'h30;
  localparam logic [7:0] ADDR_CONV      = 8'h34;
  localparam logic [7:0] ADDR_STATUS    = 8'h38;
  localparam logic [7:0] ADDR_MASK      = 8'h3C;
  localparam logic [7:0] ADDR_TMR_EN    = 8'h40;
  localparam logic [7:0] ADDR_TMR_BASE  = 8'h44;
  localparam logic [7:0] ADDR_STRIDE    = 8'h04;

  // Mode codes in control bits 3:0
  localparam logic [3:0] MODE_OFF     = 4'h0;
  localparam logic [3:0] MODE_TOGGLE  = 4'h2;
  localparam logic [3:0] MODE_SET     = 4'h8;
  localparam logic [3:0] MODE_CLEAR   = 4'h9;
  localparam logic [3:0] MODE_SWINT   = 4'hA;
  localparam logic [3:0] MODE_TRIGGER = 4'hB;

  // Timer select fields: units 0..2 in select A, units 3..4 in select B
  localparam int TSEL_LSB [NUM_UNITS] = '{0, 3, 6, 0, 2};
  localparam int TSEL_IN_B_FROM       = 3;
  localparam logic [7:0] TSEL_A_MASK  = 8'hDB;
  localparam logic [7:0] TSEL_B_MASK  = 8'h0F;
  localparam logic [1:0] TSEL_UNUSED  = 2'h3;

  // Output pin select: bit set = primary pin, clear = alternate pin
  localparam int PIN_SEL_U1 = 0;
  localparam int PIN_SEL_U2 = 2;
  localparam logic [7:0] PIN_SEL_MASK  = 8'h05;
  localparam logic [7:0] PIN_SEL_RESET = 8'h05;

  localparam int CONV_EN_BIT    = 0;
  localparam int CONV_GO_BIT    = 1;
  localparam int STATUS_OVF_LSB = 8;

  localparam logic [7:0]  CTRL_RESET = 8'h00;
  localparam logic [15:0] COUNT_ZERO = 16'h0000;
  localparam logic [15:0] COUNT_MAX  = 16'hFFFF;
endpackage : cmp_event_pkg

/* File: core/timer_compare_event_unit.sv */
// Five compare units, three 16-bit timers, AHB-Lite registers.
// Assumes timer ticks are one-cycle enables synchronous to ref_clk.
//
// Added by the designer: the AHB-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
module timer_compare_event_unit
  import cmp_event_pkg::*;
(
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        resetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // Timer clock enables and converter status
  input  wire logic [2:0]  timer_tick,
  input  wire logic        conv_done,
  output logic             conv_go,
  // Compare output pins, alternates for units 1 and 2
  output logic [4:0]       cmp_pin_o,
  output logic [4:0]       cmp_pin_oe,
  output logic [1:0]       cmp_alt_o,
  output logic [1:0]       cmp_alt_oe,
  // Interrupt
  output logic             irq
);

  function automatic logic [7:0] word_addr(logic [7:0] base, int idx);
    word_addr = base + 8'(idx * 4);
  endfunction : word_addr

  function automatic logic mode_active(logic [3:0] m);
    mode_active = (m == MODE_TOGGLE) || (m == MODE_SET) || (m == MODE_CLEAR)
               || (m == MODE_SWINT) || (m == MODE_TRIGGER);
  endfunction : mode_active

  function automatic logic mode_owns_pin(logic [3:0] m);
    mode_owns_pin = (m == MODE_TOGGLE) || (m == MODE_SET) || (m == MODE_CLEAR);
  endfunction : mode_owns_pin

  // Unused select code falls back to the first timer
  function automatic logic [1:0] timer_of(logic [1:0] s);
    timer_of = (s == TSEL_UNUSED) ? 2'h0 : s;
  endfunction : timer_of

  // Bus state
  logic        dp_valid_reg, dp_valid_next;
  logic        dp_write_reg, dp_write_next;
  logic [7:0]  dp_addr_reg,  dp_addr_next;
  logic        rd_wait_reg,  rd_wait_next;
  logic [31:0] hrdata_reg,   hrdata_next;
  // Configuration and status
  logic [7:0]  ctrl_reg  [NUM_UNITS];
  logic [7:0]  ctrl_next [NUM_UNITS];
  logic [15:0] cmp_reg   [NUM_UNITS];
  logic [15:0] cmp_next  [NUM_UNITS];
  logic [15:0] tmr_reg   [NUM_TIMERS];
  logic [15:0] tmr_next  [NUM_TIMERS];
  logic [7:0]  tsel_a_reg, tsel_a_next;
  logic [7:0]  tsel_b_reg, tsel_b_next;
  logic [7:0]  pin_sel_reg, pin_sel_next;
  logic [1:0]  conv_reg, conv_next;
  logic [10:0] status_reg, status_next;
  logic [10:0] mask_reg, mask_next;
  logic [2:0]  tmr_en_reg, tmr_en_next;
  // Per-unit compare state
  logic [4:0]  latch_reg, latch_next;
  logic [4:0]  pend_reg, pend_next;
  logic [4:0]  eqd_reg, eqd_next;
  // Decoded helpers
  logic [3:0]  mode_w [NUM_UNITS];
  logic [1:0]  sel_w  [NUM_UNITS];
  logic [4:0]  eq_w, match_evt, own_w, ctrl_wr, cmp_wr;
  logic [4:0]  swint_w;
  logic [2:0]  tick_go, rst_hit, ovf_set;
  logic        addr_take, wr_en;
  logic [31:0] rd_mux;

  always_comb begin
    for (int u = 0; u < NUM_UNITS; u++) begin
      mode_w[u] = ctrl_reg[u][3:0];
      // (R19) Timer chosen per unit
      if (u < TSEL_IN_B_FROM) begin
        sel_w[u] = timer_of(tsel_a_reg[TSEL_LSB[u] +: 2]);
      end else begin
        sel_w[u] = timer_of(tsel_b_reg[TSEL_LSB[u] +: 2]);
      end
      own_w[u] = mode_owns_pin(mode_w[u]);
      swint_w[u] = (mode_w[u] == MODE_SWINT);
    end
  end

  // Bus control: reads take one wait state so read data is registered
  always_comb begin
    addr_take     = hsel && htrans[1] && hready;
    dp_valid_next = hready ? addr_take : dp_valid_reg;
    dp_write_next = addr_take ? hwrite : dp_write_reg;
    dp_addr_next  = addr_take ? haddr[7:0] : dp_addr_reg;
    rd_wait_next  = dp_valid_reg && !dp_write_reg && !rd_wait_reg;
    wr_en         = dp_valid_reg && dp_write_reg;
    rd_mux        = 32'h0000_0000;
    for (int u = 0; u < NUM_UNITS; u++) begin
      if (dp_addr_reg == word_addr(ADDR_CTRL_BASE, u)) rd_mux = {24'h00_0000, ctrl_reg[u]};
      if (dp_addr_reg == word_addr(ADDR_CMP_BASE, u))  rd_mux = {16'h0000, cmp_reg[u]};
    end
    for (int t = 0; t < NUM_TIMERS; t++) begin
      if (dp_addr_reg == word_addr(ADDR_TMR_BASE, t)) rd_mux = {16'h0000, tmr_reg[t]};
    end
    if (dp_addr_reg == ADDR_TSEL_A)  rd_mux = {24'h00_0000, tsel_a_reg};
    if (dp_addr_reg == ADDR_TSEL_B)  rd_mux = {24'h00_0000, tsel_b_reg};
    if (dp_addr_reg == ADDR_PIN_SEL) rd_mux = {24'h00_0000, pin_sel_reg};
    if (dp_addr_reg == ADDR_CONV)    rd_mux = {30'h0000_0000, conv_reg};
    if (dp_addr_reg == ADDR_STATUS)  rd_mux = {21'h00_0000, status_reg};
    if (dp_addr_reg == ADDR_MASK)    rd_mux = {21'h00_0000, mask_reg};
    if (dp_addr_reg == ADDR_TMR_EN)  rd_mux = {29'h0000_0000, tmr_en_reg};
    hrdata_next = rd_wait_next ? rd_mux : hrdata_reg;
  end

  // Registers, timers and compare units
  always_comb begin
    tsel_a_next  = tsel_a_reg;
    tsel_b_next  = tsel_b_reg;
    pin_sel_next = pin_sel_reg;
    conv_next    = conv_reg;
    mask_next    = mask_reg;
    tmr_en_next  = tmr_en_reg;
    status_next  = status_reg;
    latch_next   = latch_reg;
    pend_next    = pend_reg;
    eqd_next     = eqd_reg;
    eq_w         = 5'h00;
    match_evt    = 5'h00;
    ctrl_wr      = 5'h00;
    cmp_wr       = 5'h00;
    rst_hit      = 3'h0;
    ovf_set      = 3'h0;
    tick_go      = tmr_en_reg & timer_tick;
    for (int u = 0; u < NUM_UNITS; u++) begin
      ctrl_next[u] = ctrl_reg[u];
      cmp_next[u]  = cmp_reg[u];
    end
    for (int t = 0; t < NUM_TIMERS; t++) begin
      tmr_next[t] = tmr_reg[t];
    end

    // Software writes first, so hardware wins below, except zeroed control over a match and control/compare writes over a pending clear
    if (wr_en) begin
      for (int u = 0; u < NUM_UNITS; u++) begin
        if (dp_addr_reg == word_addr(ADDR_CTRL_BASE, u)) begin
          ctrl_wr[u]   = 1'b1;
          ctrl_next[u] = hwdata[7:0];
          pend_next[u] = 1'b0;
          // (R7) Zero or set mode starts latch low
          if (hwdata[3:0] == MODE_OFF || hwdata[3:0] == MODE_SET) latch_next[u] = 1'b0;
          if (hwdata[3:0] == MODE_CLEAR) latch_next[u] = 1'b1;
        end
        if (dp_addr_reg == word_addr(ADDR_CMP_BASE, u)) begin
          cmp_wr[u]    = 1'b1;
          cmp_next[u]  = hwdata[15:0];
          // (R15) Rewrite cancels pending clear
          pend_next[u] = 1'b0;
        end
      end
      if (dp_addr_reg == ADDR_TSEL_A)  tsel_a_next  = hwdata[7:0] & TSEL_A_MASK;
      if (dp_addr_reg == ADDR_TSEL_B)  tsel_b_next  = hwdata[7:0] & TSEL_B_MASK;
      if (dp_addr_reg == ADDR_PIN_SEL) pin_sel_next = hwdata[7:0] & PIN_SEL_MASK;
      if (dp_addr_reg == ADDR_CONV)    conv_next    = hwdata[1:0];
      if (dp_addr_reg == ADDR_STATUS)  status_next  = status_reg & ~hwdata[10:0];
      if (dp_addr_reg == ADDR_MASK)    mask_next    = hwdata[10:0];
      if (dp_addr_reg == ADDR_TMR_EN)  tmr_en_next  = hwdata[2:0];
    end
    if (conv_done) conv_next[CONV_GO_BIT] = 1'b0;

    // (R12) Pending clear taken on the timer's next tick
    for (int u = 0; u < NUM_UNITS; u++) begin
      if (pend_reg[u] && !cmp_wr[u] && !ctrl_wr[u] && tick_go[sel_w[u]]) begin
        rst_hit[sel_w[u]] = 1'b1;
        pend_next[u]      = 1'b0;
      end
    end
    for (int t = 0; t < NUM_TIMERS; t++) begin
      if (tick_go[t]) begin
        // (R3) Clear to zero, no overflow flag
        if (rst_hit[t]) begin
          tmr_next[t] = COUNT_ZERO;
        end else begin
          tmr_next[t] = tmr_reg[t] + 16'h0001;
          // (R14) Only a genuine rollover flags
          ovf_set[t]  = (tmr_reg[t] == COUNT_MAX);
        end
      end
    end

    for (int u = 0; u < NUM_UNITS; u++) begin
      // (R1) Equality against the selected timer
      eq_w[u]      = (cmp_reg[u] == tmr_reg[sel_w[u]]);
      eqd_next[u]  = eq_w[u];
      // Edge detect: a timer parked on the value fires once
      match_evt[u] = eq_w[u] && !eqd_reg[u] && mode_active(mode_w[u]);
      if (match_evt[u]) begin
        unique case (mode_w[u])
          // (R18) Pin latch actions
          MODE_TOGGLE: latch_next[u] = ~latch_reg[u];
          MODE_SET:    latch_next[u] = 1'b1;
          MODE_CLEAR:  latch_next[u] = 1'b0;
          // (R10) Flag only
          MODE_SWINT:  latch_next[u] = latch_reg[u];
          // (R16) Period reload via pending clear
          MODE_TRIGGER: begin
            pend_next[u] = 1'b1;
            // (R4) Fifth unit starts a conversion
            if (u == ADC_UNIT && conv_reg[CONV_EN_BIT]) conv_next[CONV_GO_BIT] = 1'b1;
          end
          default:     latch_next[u] = latch_reg[u];
        endcase
      end
      // (R7) Clearing control beats a match
      if (ctrl_wr[u] && ctrl_next[u] == CTRL_RESET) latch_next[u] = 1'b0;
    end
    // (R2) (R11) Flag set with the action, set beats clear
    status_next[4:0] = status_next[4:0] | match_evt;
    status_next[STATUS_OVF_LSB +: 3] = status_next[STATUS_OVF_LSB +: 3] | ovf_set;
  end

  // Outputs
  always_comb begin
    hreadyout = !(dp_valid_reg && !dp_write_reg && !rd_wait_reg);
    hresp     = 1'b0;
    hrdata    = hrdata_reg;
    conv_go   = conv_reg[CONV_GO_BIT];
    irq       = |(status_reg & mask_reg);
    cmp_pin_o = latch_reg;
    // (R13) Only toggle, set and clear modes own a pin
    cmp_pin_oe = own_w;
    // (R6) Units 1 and 2 steered by pin select
    cmp_pin_oe[1] = own_w[1] && pin_sel_reg[PIN_SEL_U1];
    cmp_pin_oe[2] = own_w[2] && pin_sel_reg[PIN_SEL_U2];
    cmp_alt_o     = latch_reg[2:1];
    cmp_alt_oe[0] = own_w[1] && !pin_sel_reg[PIN_SEL_U1];
    cmp_alt_oe[1] = own_w[2] && !pin_sel_reg[PIN_SEL_U2];
  end

  // (R17) All state advances on ref_clk only
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      dp_valid_reg <= 1'b0;
      dp_write_reg <= 1'b0;
      dp_addr_reg  <= 8'h00;
      rd_wait_reg  <= 1'b0;
      hrdata_reg   <= 32'h0000_0000;
      for (int u = 0; u < NUM_UNITS; u++) begin
        ctrl_reg[u] <= CTRL_RESET;
        cmp_reg[u]  <= COUNT_ZERO;
      end
      for (int t = 0; t < NUM_TIMERS; t++) begin
        tmr_reg[t] <= COUNT_ZERO;
      end
      tsel_a_reg  <= 8'h00;
      tsel_b_reg  <= 8'h00;
      pin_sel_reg <= PIN_SEL_RESET;
      conv_reg    <= 2'h0;
      status_reg  <= 11'h000;
      mask_reg    <= 11'h000;
      tmr_en_reg  <= 3'h0;
      latch_reg   <= 5'h00;
      pend_reg    <= 5'h00;
      // Compare and timers reset equal, so no false edge
      eqd_reg     <= 5'h1F;
    end else begin
      dp_valid_reg <= dp_valid_next;
      dp_write_reg <= dp_write_next;
      dp_addr_reg  <= dp_addr_next;
      rd_wait_reg  <= rd_wait_next;
      hrdata_reg   <= hrdata_next;
      ctrl_reg     <= ctrl_next;
      cmp_reg      <= cmp_next;
      tmr_reg      <= tmr_next;
      tsel_a_reg   <= tsel_a_next;
      tsel_b_reg   <= tsel_b_next;
      pin_sel_reg  <= pin_sel_next;
      conv_reg     <= conv_next;
      status_reg   <= status_next;
      mask_reg     <= mask_next;
      tmr_en_reg   <= tmr_en_next;
      latch_reg    <= latch_next;
      pend_reg     <= pend_next;
      eqd_reg      <= eqd_next;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  // Trigger checks watch the fifth unit, the one that also starts conversions
  sequence s_trigger_armed;
    match_evt[ADC_UNIT] && mode_w[ADC_UNIT] == MODE_TRIGGER;
  endsequence
  sequence s_tick_taken;
    pend_reg[ADC_UNIT] && !cmp_wr[ADC_UNIT] && !ctrl_wr[ADC_UNIT]
      && tick_go[sel_w[ADC_UNIT]];
  endsequence
  // Converter untouched by software and idle
  sequence s_conv_quiet;
    !wr_en && !conv_reg[CONV_GO_BIT];
  endsequence

  // Match and flag
  a_eq_to_match: assert property ($rose(eq_w[0]) && mode_active(mode_w[0]) |-> match_evt[0]) // R1
    else $error("equality in active mode gave no match");
  a_flag_with_match: assert property (match_evt[3] |=> status_reg[3]) // R2
    else $error("match flag not set after match");
  a_flag_all_units: assert property (match_evt != 5'h00 // R2
    |=> (status_reg[4:0] & $past(match_evt)) == $past(match_evt))
    else $error("match flag missing after match");
  a_off_no_flag: assert property (mode_w[0] == MODE_OFF |=> !$rose(status_reg[0])) // R18
    else $error("disabled unit raised its flag");

  // Trigger, timers and converter
  a_trigger_flag: assert property (s_trigger_armed // R11
    |=> status_reg[ADC_UNIT] && pend_reg[ADC_UNIT])
    else $error("trigger match did not flag and arm");
  a_timer_cleared: assert property (s_tick_taken // R12
    |=> tmr_reg[$past(sel_w[ADC_UNIT])] == COUNT_ZERO)
    else $error("timer not cleared on tick after trigger");
  a_tick_count: assert property (tick_go[1] && !rst_hit[1] // R16
    |=> tmr_reg[1] == $past(tmr_reg[1]) + 16'h0001)
    else $error("timer did not count on its tick");
  a_ovf_true_roll: assert property ($rose(status_reg[STATUS_OVF_LSB]) // R14
                                    |-> $past(tmr_reg[0]) == COUNT_MAX)
    else $error("overflow flag without rollover");
  a_conv_start: assert property (match_evt[ADC_UNIT] && mode_w[ADC_UNIT] == MODE_TRIGGER // R4
                                 && conv_reg[CONV_EN_BIT] |=> conv_go)
    else $error("conversion not started by trigger");
  a_conv_needs_en: assert property (!conv_reg[CONV_EN_BIT] ##0 s_conv_quiet |=> !conv_go) // R4
    else $error("conversion started while converter off");
  a_go_cleared: assert property (conv_done && !match_evt[ADC_UNIT] && !wr_en |=> !conv_go) // R4
    else $error("conversion go not cleared by done");
  a_rewrite_cancel: assert property (cmp_wr[ADC_UNIT] && !match_evt[ADC_UNIT] // R15
    |=> !pend_reg[ADC_UNIT])
    else $error("compare rewrite left clear pending");

  // Pin ownership and steering
  a_swint_no_pin: assert property (mode_w[0] == MODE_SWINT |-> !cmp_pin_oe[0]) // R10
    else $error("software interrupt mode drives pin");
  a_swint_any_pin: assert property ((swint_w & cmp_pin_oe) == 5'h00 // R10
    && (swint_w[2:1] & cmp_alt_oe) == 2'h0)
    else $error("flag only mode enables a pin");
  a_trigger_no_pin: assert property (mode_w[ADC_UNIT] == MODE_TRIGGER // R13
                                     |-> !cmp_pin_oe[ADC_UNIT])
    else $error("trigger mode drives pin");
  a_pin_primary: assert property (own_w[1] && pin_sel_reg[PIN_SEL_U1] // R6
    |-> cmp_pin_oe[1] && !cmp_alt_oe[0])
    else $error("unit 1 not on its primary pin");
  a_pin_alt: assert property (own_w[2] && !pin_sel_reg[PIN_SEL_U2] // R6
    |-> cmp_alt_oe[1] && !cmp_pin_oe[2])
    else $error("unit 2 not on its alternate pin");

  // Latch actions
  a_zero_ctrl_low: assert property (ctrl_wr[2] && ctrl_next[2] == CTRL_RESET // R7
                                    |=> !latch_reg[2] ##1 !latch_reg[2])
    else $error("latch not forced low by zero control");
  a_toggle_action: assert property (match_evt[0] && mode_w[0] == MODE_TOGGLE && !ctrl_wr[0] // R18
                                    |=> latch_reg[0] != $past(latch_reg[0]))
    else $error("toggle mode did not toggle");
  a_set_action: assert property (match_evt[0] && mode_w[0] == MODE_SET && !ctrl_wr[0] // R18
    |=> latch_reg[0])
    else $error("set mode did not set latch");
  a_clear_action: assert property (match_evt[0] && mode_w[0] == MODE_CLEAR // R18
    |=> !latch_reg[0])
    else $error("clear mode did not clear latch");

endmodule : timer_compare_event_unit
`default_nettype wire

/* File: tb/cmp_pin_load.sv */
// Load on the seven compare pins: primary pins, then the two alternates.
// Assumes a pull-down on every pin, so an undriven pin reads low.
`timescale 1ns/1ns
`default_nettype none
module cmp_pin_load (
  // Pin drivers from the block
  input  wire logic [6:0] pin_o,
  input  wire logic [6:0] pin_oe,
  // Level seen on the board
  output logic      [6:0] pin_level
);
  assign pin_level = pin_o & pin_oe;
endmodule : cmp_pin_load
`default_nettype wire

/* File: tb/timer_compare_event_unit_tb.sv */
// Bench for the compare/event block: registers, compare modes, trigger.
// Assumes the design package is compiled first; hready loops back.
`timescale 1ns/1ns
`default_nettype none
module timer_compare_event_unit_tb
  import cmp_event_pkg::*;
;
  logic        ref_clk;
  logic        resetn;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic        hreadyout;
  logic        hresp;
  logic [31:0] hrdata;
  logic [2:0]  timer_tick;
  logic        conv_done;
  logic        conv_go;
  logic [4:0]  cmp_pin_o;
  logic [4:0]  cmp_pin_oe;
  logic [1:0]  cmp_alt_o;
  logic [1:0]  cmp_alt_oe;
  logic        irq;
  logic [6:0]  pin_level;
  logic [7:0]  psel;
  logic [31:0] q;
  int          error_cnt;
  int          n_compared;
  localparam logic [3:0] mode_list [4] = '{MODE_TOGGLE, MODE_SET, MODE_CLEAR, MODE_SWINT};

  timer_compare_event_unit u_dut (
    .ref_clk(ref_clk), .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .timer_tick(timer_tick),
    .conv_done(conv_done), .conv_go(conv_go), .cmp_pin_o(cmp_pin_o),
    .cmp_pin_oe(cmp_pin_oe), .cmp_alt_o(cmp_alt_o), .cmp_alt_oe(cmp_alt_oe), .irq(irq)
  );

  cmp_pin_load u_load (
    .pin_o({cmp_alt_o, cmp_pin_o}), .pin_oe({cmp_alt_oe, cmp_pin_oe}), .pin_level(pin_level)
  );

  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  task automatic stop_test;
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : stop_test

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // Address phase held until hready, then data phase held until hready
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    @(posedge ref_clk);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    hsize  <= 3'h2;
    haddr  <= {24'h0, a};
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    if (wr) begin
      hwdata <= d;
    end
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    r = hrdata;
    chk("hresp", 32'h0, 32'(hresp));
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] r);
    bus(1'b0, a, 32'h0, r);
  endtask : rd

  task automatic tick(input int t, input int n);
    repeat (n) begin
      @(posedge ref_clk);
      timer_tick <= 3'h1 << t;
      @(posedge ref_clk);
      timer_tick <= 3'h0;
    end
  endtask : tick

  function automatic logic exp_latch(input logic [3:0] m);
    return m == MODE_TOGGLE || m == MODE_SET;
  endfunction : exp_latch

  function automatic logic [6:0] exp_oe(input int u, input logic [3:0] m);
    logic [6:0] v;
    v = 7'h0;
    if (m == MODE_TOGGLE || m == MODE_SET || m == MODE_CLEAR) begin
      if (u == 1 && !psel[PIN_SEL_U1]) v[5] = 1'b1;
      else if (u == 2 && !psel[PIN_SEL_U2]) v[6] = 1'b1;
      else v[u] = 1'b1;
    end
    return v;
  endfunction : exp_oe

  task automatic run_mode(input int u, input logic [3:0] m, input logic [1:0] code);
    int          t;
    int          k;
    logic [31:0] r;
    logic [31:0] mask;
    logic [7:0]  ctl;
    t = (code == TSEL_UNUSED) ? 0 : int'(code);
    k = $urandom_range(4, 1);
    mask = (m == MODE_SWINT) ? 32'h0 : 32'h1 << u;
    ctl = ADDR_CTRL_BASE + ADDR_STRIDE * 8'(u);
    wr(ctl, 32'h0);
    wr(u >= TSEL_IN_B_FROM ? ADDR_TSEL_B : ADDR_TSEL_A, 32'(code) << TSEL_LSB[u]);
    wr(ADDR_MASK, mask);
    rd(ADDR_TMR_BASE + ADDR_STRIDE * 8'(t), r);
    wr(ADDR_CMP_BASE + ADDR_STRIDE * 8'(u), {16'h0, r[15:0] + 16'(k)});
    wr(ctl, {28'h0, m});
    tick(t, k);
    repeat (2) @(posedge ref_clk);
    rd(ADDR_STATUS, r);
    chk("match flag", 32'h1, 32'(r[u]));
    chk("latch", 32'(exp_latch(m)), 32'(cmp_pin_o[u]));
    chk("pin enable", 32'(exp_oe(u, m)), {25'h0, cmp_alt_oe, cmp_pin_oe});
    chk("pin level", 32'(exp_oe(u, m) & {7{exp_latch(m)}}), 32'(pin_level));
    chk("irq", 32'(mask != 32'h0), 32'(irq));
    wr(ADDR_STATUS, 32'h1 << u);
    rd(ADDR_STATUS, r);
    chk("flag cleared", 32'h0, 32'(r[u]));
    chk("irq cleared", 32'h0, 32'(irq));
    wr(ctl, 32'h0);
    repeat (2) @(posedge ref_clk);
    chk("latch off", 32'h0, 32'(cmp_pin_o[u]));
  endtask : run_mode

  task automatic run_trigger(input logic en, input logic [1:0] code);
    int          t;
    int          n;
    logic [31:0] r;
    logic [15:0] p;
    logic [7:0]  ta;
    logic [7:0]  ca;
    logic [7:0]  ctl;
    t = (code == TSEL_UNUSED) ? 0 : int'(code);
    n = $urandom_range(6, 3);
    ta = ADDR_TMR_BASE + ADDR_STRIDE * 8'(t);
    ca = ADDR_CMP_BASE + ADDR_STRIDE * 8'(ADC_UNIT);
    ctl = ADDR_CTRL_BASE + ADDR_STRIDE * 8'(ADC_UNIT);
    wr(ADDR_CONV, {31'h0, en});
    wr(ADDR_TSEL_B, 32'(code) << TSEL_LSB[ADC_UNIT]);
    rd(ta, r);
    p = r[15:0] + 16'(n);
    wr(ca, {16'h0, p});
    wr(ctl, {28'h0, MODE_TRIGGER});
    wr(ADDR_STATUS, 32'h7FF);
    tick(t, n);
    repeat (2) @(posedge ref_clk);
    chk("conv go", 32'(en), 32'(conv_go));
    chk("trigger pins", 32'h0, {25'h0, cmp_alt_oe, cmp_pin_oe});
    rd(ADDR_STATUS, r);
    chk("trigger flag", 32'h1 << ADC_UNIT, r & (32'h1 << ADC_UNIT));
    rd(ta, r);
    chk("timer held", {16'h0, p}, r);
    tick(t, 1);
    rd(ta, r);
    chk("timer cleared", 32'h0, r);
    rd(ADDR_STATUS, r);
    chk("no overflow", 32'h0, r & (32'h1 << (STATUS_OVF_LSB + t)));
    @(posedge ref_clk);
    conv_done <= 1'b1;
    @(posedge ref_clk);
    conv_done <= 1'b0;
    repeat (2) @(posedge ref_clk);
    chk("conv go done", 32'h0, 32'(conv_go));
    wr(ADDR_STATUS, 32'h7FF);
    tick(t, int'(p));
    repeat (2) @(posedge ref_clk);
    rd(ADDR_STATUS, r);
    chk("period flag", 32'h1 << ADC_UNIT, r & (32'h1 << ADC_UNIT));
    wr(ca, {16'h0, p + 16'h7});
    tick(t, 1);
    rd(ta, r);
    chk("clear cancelled", {16'h0, p + 16'h1}, r);
    wr(ctl, 32'h0);
  endtask : run_trigger

  initial begin
    repeat (20000) @(posedge ref_clk);
    error_cnt++;
    $display("MISMATCH watchdog expected done seen hang");
    stop_test;
  end

  initial begin
    resetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    timer_tick = 3'h0;
    conv_done = 1'b0;
    psel = PIN_SEL_RESET;
    error_cnt = 0;
    n_compared = 0;
    void'($urandom(32'h2337));
    repeat (2) @(posedge ref_clk);
    resetn <= 1'b1;
    for (int u = 0; u < NUM_UNITS; u++) begin
      rd(ADDR_CTRL_BASE + ADDR_STRIDE * 8'(u), q);
      chk("control reset", {24'h0, CTRL_RESET}, q);
    end
    rd(ADDR_PIN_SEL, q);
    chk("pin select reset", {24'h0, PIN_SEL_RESET}, q);
    wr(8'hFC, 32'hFFFF_FFFF);
    rd(8'hFC, q);
    chk("unmapped", 32'h0, q);
    wr(ADDR_TMR_EN, 32'h7);
    $display("test registers done");
    for (int i = 0; i < 8; i++) begin
      run_mode($urandom_range(4, 0), mode_list[i % 4], 2'($urandom_range(3, 0)));
    end
    $display("test modes done");
    psel = 8'h00;
    wr(ADDR_PIN_SEL, 32'h0);
    run_mode(1, MODE_SET, 2'h1);
    run_mode(2, MODE_TOGGLE, 2'h3);
    $display("test pin select done");
    run_trigger(1'b1, 2'($urandom_range(3, 0)));
    run_trigger(1'b0, 2'($urandom_range(3, 0)));
    $display("test trigger done");
    stop_test;
  end
endmodule : timer_compare_event_unit_tb
`default_nettype wire
